/* File: src/sync_burst_pkg.sv */
// shared constants, types and helpers of the synchronous burst memory
package sync_burst_pkg;

  // ---------------------------------------------------------------
  // organisation: 256K words of 36 bits, four lanes of nine bits
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 18;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int DEPTH   = 262144;
  localparam int BURST_W = 2;

  // ---------------------------------------------------------------
  // mode pin encodings and their unconnected defaults
  // ---------------------------------------------------------------
  localparam logic ORDER_LINEAR      = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;
  localparam logic OUT_FLOW          = 1'b0;
  localparam logic OUT_PIPELINED     = 1'b1;
  localparam logic ORDER_DEFAULT     = ORDER_INTERLEAVED;
  localparam logic OUT_DEFAULT       = OUT_PIPELINED;
  localparam logic SLEEP_DEFAULT     = 1'b0;

  // ---------------------------------------------------------------
  // reset values and masks
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] STEP_ZERO  = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE   = 2'h1;
  localparam logic [LANES-1:0]   LANES_ALL  = 4'hf;
  localparam logic [LANES-1:0]   LANES_NONE = 4'h0;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 18'h00000;
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 36'h000000000;

  typedef enum logic {
    burst_idle,
    burst_active
  } burst_state_e;

  // ---------------------------------------------------------------
  // burst address sequence
  // ---------------------------------------------------------------
  function automatic logic [BURST_W-1:0] burst_lsbs(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] step,
    input logic               order
  );
    if (order == ORDER_LINEAR) begin
      burst_lsbs = BURST_W'(start + step);
    end else begin
      burst_lsbs = start ^ step;
    end
  endfunction

endpackage

/* File: src/burst_ctl_if.sv */
// link between the access control and the burst address counter
`timescale 1ns/1ps
interface burst_ctl_if;
  import sync_burst_pkg::*;

  logic               load;
  logic               advance;
  logic [BURST_W-1:0] preset;
  logic               order;
  logic [BURST_W-1:0] cur_lsbs;
  logic [BURST_W-1:0] adv_lsbs;

  modport ctrl (
    output load,
    output advance,
    output preset,
    output order,
    input  cur_lsbs,
    input  adv_lsbs
  );

  modport cnt (
    input  load,
    input  advance,
    input  preset,
    input  order,
    output cur_lsbs,
    output adv_lsbs
  );
endinterface

/* File: src/burst_counter.sv */
// two-bit burst address counter with linear and interleaved order
`timescale 1ns/1ps
module burst_counter
  import sync_burst_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  // control side
  burst_ctl_if.cnt  ctl
);

  logic [BURST_W-1:0] start;
  logic [BURST_W-1:0] step;
  logic [BURST_W-1:0] next_start;
  logic [BURST_W-1:0] next_step;

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always_comb begin
    next_start = start;
    next_step  = step;
    if (ctl.load) begin
      next_start = ctl.preset;
      next_step  = STEP_ZERO;
    end else if (ctl.advance) begin
      next_step = BURST_W'(step + STEP_ONE);
    end
  end

  assign ctl.cur_lsbs = burst_lsbs(start, step, ctl.order);
  assign ctl.adv_lsbs = burst_lsbs(start, BURST_W'(step + STEP_ONE), ctl.order);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start <= STEP_ZERO;
      step  <= STEP_ZERO;
    end else begin
      start <= next_start;
      step  <= next_step;
    end
  end

endmodule

/* File: src/sync_burst_sram_dcd.sv */
// synchronous burst static memory with dual-cycle deselect
//
// Notes on behaviour
// - two-bit counter preset from address lsbs
// - all sync inputs sampled on rising edge
// - output enable and sleep act asynchronously
// - either address strobe low starts a burst
// - counter advances only when advance low
// - order pin low linear, high interleaved
// - mode low flow-through, high registered output
// - open mode pins give interleaved pipelined
// - deselect pipelined as deep as read
// - byte write enable writes selected lanes
// - global write writes all lanes
// - sleep pin saves power, keeps data
// - selected when low enable low, high high
// - data driven only while output enable low
// - each active-low lane select owns one lane
// - write completes internally without extra strobe
// - array of 256K words by 36 bits
// - sleep low or open means active
`timescale 1ns/1ps
module sync_burst_sram_dcd
  import sync_burst_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  // address and strobes
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              processor_addr_strobe_n_i,
  input  wire logic              controller_addr_strobe_n_i,
  input  wire logic              burst_advance_n_i,
  // chip selects
  input  wire logic              chip_select_low_n_i,
  input  wire logic              chip_select_high_i,
  // write controls
  input  wire logic              all_bytes_write_n_i,
  input  wire logic              byte_write_enable_n_i,
  input  wire logic [LANES-1:0]  byte_lane_select_n_i,
  // data lanes, split two-way pin
  input  wire logic [DATA_W-1:0] data_byte_lane_i,
  output logic      [DATA_W-1:0] data_byte_lane_o,
  output logic      [LANES-1:0]  data_byte_lane_oe_o,
  // asynchronous controls
  input  wire logic              output_enable_n_i,
  input  wire logic              sleep_request_i = SLEEP_DEFAULT,
  // mode pins, defaults stand for an open pin
  input  wire logic              burst_order_select_i = ORDER_DEFAULT,
  input  wire logic              output_mode_select_i = OUT_DEFAULT
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [DEPTH];

  burst_ctl_if ctl ();

  burst_counter counter_u (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ctl        (ctl.cnt)
  );

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  burst_state_e              state;
  burst_state_e              next_state;
  logic [ADDR_W-BURST_W-1:0] base_hi;
  logic [ADDR_W-BURST_W-1:0] next_base_hi;
  logic                      awake;
  logic                      strobe;
  logic                      selected;
  logic                      continuing;
  logic                      is_write;
  logic [LANES-1:0]          lane_mask;
  logic [ADDR_W-1:0]         access_addr;
  logic                      do_read;
  logic                      do_write;
  logic                      deselect;

  always_comb begin
    awake    = ~sleep_request_i;
    strobe   = ~processor_addr_strobe_n_i | ~controller_addr_strobe_n_i;
    selected = ~chip_select_low_n_i & chip_select_high_i;
    // global write wins over the per-lane selects
    if (!all_bytes_write_n_i) begin
      lane_mask = LANES_ALL;
    end else if (!byte_write_enable_n_i) begin
      lane_mask = ~byte_lane_select_n_i;
    end else begin
      lane_mask = LANES_NONE;
    end
    // a processor strobe always opens with a read
    is_write   = (lane_mask != LANES_NONE) & processor_addr_strobe_n_i;
    continuing = ~strobe & (state == burst_active);
    deselect   = awake & strobe & ~selected;
    if (strobe) begin
      access_addr = addr_i;
    end else if (!burst_advance_n_i) begin
      access_addr = {base_hi, ctl.adv_lsbs};
    end else begin
      access_addr = {base_hi, ctl.cur_lsbs};
    end
    do_write = awake & ((strobe & selected) | continuing) & is_write;
    do_read  = awake & ((strobe & selected) | continuing) & ~is_write;
  end

  always_comb begin
    ctl.load     = awake & strobe & selected;
    ctl.advance  = awake & continuing & ~burst_advance_n_i;
    ctl.preset   = addr_i[BURST_W-1:0];
    ctl.order    = burst_order_select_i;
    next_state   = state;
    next_base_hi = base_hi;
    if (awake) begin
      if (strobe && selected) begin
        next_state   = burst_active;
        next_base_hi = addr_i[ADDR_W-1:BURST_W];
      end else if (strobe) begin
        next_state = burst_idle;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state   <= burst_idle;
      base_hi <= '0;
    end else begin
      state   <= next_state;
      base_hi <= next_base_hi;
    end
  end

  // ---------------------------------------------------------------
  // self-timed write
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (do_write) begin
      for (int l = 0; l < LANES; l++) begin
        if (lane_mask[l]) begin
          mem[access_addr][l*LANE_W +: LANE_W] <= data_byte_lane_i[l*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read and deselect pipeline
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] rd_addr;
  logic [ADDR_W-1:0] next_rd_addr;
  logic              drive_early;
  logic              next_drive_early;
  logic              drive_late;
  logic              next_drive_late;
  logic [DATA_W-1:0] out_reg;
  logic [DATA_W-1:0] next_out_reg;
  logic [DATA_W-1:0] array_word;

  always_comb begin
    array_word       = mem[rd_addr];
    next_rd_addr     = rd_addr;
    next_drive_early = drive_early;
    if (do_read) begin
      next_rd_addr     = access_addr;
      next_drive_early = 1'b1;
    end else if (do_write || deselect) begin
      next_drive_early = 1'b0;
    end
    // second stage follows the first by one edge
    next_drive_late = drive_late;
    next_out_reg    = out_reg;
    if (awake) begin
      next_drive_late = drive_early;
      next_out_reg    = array_word;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_addr     <= ADDR_ZERO;
      drive_early <= 1'b0;
      drive_late  <= 1'b0;
      out_reg     <= DATA_ZERO;
    end else begin
      rd_addr     <= next_rd_addr;
      drive_early <= next_drive_early;
      drive_late  <= next_drive_late;
      out_reg     <= next_out_reg;
    end
  end

  // ---------------------------------------------------------------
  // output drive, enable and sleep take effect at once
  // ---------------------------------------------------------------
  logic drive;

  always_comb begin
    if (output_mode_select_i == OUT_FLOW) begin
      data_byte_lane_o = array_word;
      drive            = drive_early;
    end else begin
      data_byte_lane_o = out_reg;
      drive            = drive_late;
    end
    data_byte_lane_oe_o = {LANES{drive & ~output_enable_n_i & awake}};
  end

endmodule

/* File: test/host_bus_model.sv */
// host side of the shared data wire
`timescale 1ns/1ps
module host_bus_model
  import sync_burst_pkg::*;
(
  // host drive
  input  wire logic              host_oe_i,
  input  wire logic [DATA_W-1:0] host_data_i,
  // device drive
  input  wire logic [DATA_W-1:0] dev_data_i,
  input  wire logic [LANES-1:0]  dev_oe_i,
  // resolved wire
  output logic      [DATA_W-1:0] bus_o
);
  // a lane nobody drives inverts on every input change so it never reads as a stale value
  always @(host_oe_i or host_data_i or dev_data_i or dev_oe_i) begin
    for (int l = 0; l < LANES; l++) begin
      if (dev_oe_i[l]) begin
        bus_o[l*LANE_W +: LANE_W] = dev_data_i[l*LANE_W +: LANE_W];
      end else if (host_oe_i) begin
        bus_o[l*LANE_W +: LANE_W] = host_data_i[l*LANE_W +: LANE_W];
      end else begin
        bus_o[l*LANE_W +: LANE_W] = ~bus_o[l*LANE_W +: LANE_W];
      end
    end
  end
endmodule

/* File: test/sync_burst_sram_dcd_sva.sv */
// port checker of the synchronous burst memory
`timescale 1ns/1ps
module sync_burst_sram_dcd_sva
  import sync_burst_pkg::*;
(
  // watched ports
  input wire logic              core_clk_i,
  input wire logic              arst_n_i,
  input wire logic              processor_addr_strobe_n_i,
  input wire logic              controller_addr_strobe_n_i,
  input wire logic              chip_select_low_n_i,
  input wire logic              chip_select_high_i,
  input wire logic              all_bytes_write_n_i,
  input wire logic              byte_write_enable_n_i,
  input wire logic [LANES-1:0]  byte_lane_select_n_i,
  input wire logic [DATA_W-1:0] data_byte_lane_o,
  input wire logic [LANES-1:0]  data_byte_lane_oe_o,
  input wire logic              output_enable_n_i,
  input wire logic              sleep_request_i,
  input wire logic              output_mode_select_i
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic sel, stb, wr, rd, ds, pipe, on;
  logic [LANES-1:0] oe;
  assign oe   = data_byte_lane_oe_o;
  assign sel  = !chip_select_low_n_i && chip_select_high_i;
  assign stb  = !processor_addr_strobe_n_i || !controller_addr_strobe_n_i;
  assign wr   = !all_bytes_write_n_i || (!byte_write_enable_n_i && !(&byte_lane_select_n_i));
  assign rd   = !sleep_request_i && stb && sel && (!processor_addr_strobe_n_i || !wr);
  assign ds   = !sleep_request_i && stb && !sel;
  assign pipe = output_mode_select_i == OUT_PIPELINED;
  assign on   = !output_enable_n_i && !sleep_request_i;

  oe_gate_a: assert property (output_enable_n_i |-> oe == LANES_NONE)
    else $error("data driven with output enable off");
  sleep_off_a: assert property (sleep_request_i |-> oe == LANES_NONE)
    else $error("data driven while asleep");
  lanes_same_a: assert property (oe == LANES_NONE || oe == LANES_ALL)
    else $error("lane enables differ");
  pipe_read_a: assert property (rd && pipe |=> ##1 (!on || oe == LANES_ALL))
    else $error("pipelined read not driven after two edges");
  flow_read_a: assert property (rd && !pipe |=> (!on || oe == LANES_ALL))
    else $error("flow read not driven after one edge");
  pipe_desel_a: assert property (ds && pipe |=> ##1 oe == LANES_NONE)
    else $error("pipelined deselect did not release");
  flow_desel_a: assert property (ds && !pipe |=> oe == LANES_NONE)
    else $error("flow deselect did not release");
  write_quiet_a: assert property (!rd && sel && stb && wr && !sleep_request_i && pipe
    |=> ##1 oe == LANES_NONE)
    else $error("write cycle drove data");
  sleep_hold_a: assert property (sleep_request_i && $past(sleep_request_i) && pipe
    |-> $stable(data_byte_lane_o))
    else $error("output register moved while asleep");

  cover property (rd && pipe);
  cover property (rd && !pipe);
  cover property (ds);
endmodule

bind sync_burst_sram_dcd sync_burst_sram_dcd_sva chk_u (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .processor_addr_strobe_n_i(processor_addr_strobe_n_i),
  .controller_addr_strobe_n_i(controller_addr_strobe_n_i),
  .chip_select_low_n_i(chip_select_low_n_i), .chip_select_high_i(chip_select_high_i),
  .all_bytes_write_n_i(all_bytes_write_n_i), .byte_write_enable_n_i(byte_write_enable_n_i),
  .byte_lane_select_n_i(byte_lane_select_n_i), .data_byte_lane_o(data_byte_lane_o),
  .data_byte_lane_oe_o(data_byte_lane_oe_o), .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i), .output_mode_select_i(output_mode_select_i)
);

/* File: test/sync_burst_sram_dcd_bench.sv */
// self-checking bench of the synchronous burst memory
`timescale 1ns/1ps
module sync_burst_sram_dcd_bench;
  import sync_burst_pkg::*;
  localparam logic [DATA_W-1:0] BASE = 36'h0a5000000;
  logic              clk, rst_n, pst_n, cst_n, adv_n, csl_n, sh, gw_n, bw_n;
  logic              oe_n, zz, ord, fm, hoe;
  logic [LANES-1:0]  ln_n, doe;
  logic [ADDR_W-1:0] a;
  logic [DATA_W-1:0] hd, dq, bus;
  logic [DATA_W-1:0] eq[$];
  logic              ev[$];
  int                err_count, n_tests;
  int                rk[6] = '{2, 0, 0, 3, 0, 0};
  int                ri[6] = '{1, 2, 3, 3, 0, 1};

  sync_burst_sram_dcd dut_u (.core_clk_i(clk), .arst_n_i(rst_n), .addr_i(a),
    .processor_addr_strobe_n_i(pst_n), .controller_addr_strobe_n_i(cst_n),
    .burst_advance_n_i(adv_n), .chip_select_low_n_i(csl_n), .chip_select_high_i(sh),
    .all_bytes_write_n_i(gw_n), .byte_write_enable_n_i(bw_n), .byte_lane_select_n_i(ln_n),
    .data_byte_lane_i(bus), .data_byte_lane_o(dq), .data_byte_lane_oe_o(doe),
    .output_enable_n_i(oe_n), .sleep_request_i(zz), .burst_order_select_i(ord),
    .output_mode_select_i(fm));
  host_bus_model host_u (.host_oe_i(hoe), .host_data_i(hd), .dev_data_i(dq),
    .dev_oe_i(doe), .bus_o(bus));

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // k: 0 advance, 1 controller strobe, 2 processor strobe, 3 hold; d is write or expected data
  task automatic op(input int k, input logic [ADDR_W-1:0] ad, input logic g, input logic b,
                    input logic [LANES-1:0] wl, input logic [DATA_W-1:0] d, input logic e,
                    input logic s = 1'b1);
    logic [DATA_W-1:0] x;
    logic              v;
    @(posedge clk);
    pst_n <= !(k == 2);
    cst_n <= !(k == 1);
    adv_n <= (k != 0);
    a     <= ad;
    gw_n  <= g;
    bw_n  <= b;
    ln_n  <= wl;
    sh    <= s;
    hd    <= d;
    hoe   <= (k != 2) && (!g || !b);
    oe_n  <= (k != 2) && (!g || !b);
    #1;
    eq.push_back(d);
    ev.push_back(e);
    if (eq.size() > ((fm == OUT_PIPELINED) ? 2 : 1)) begin
      x = eq.pop_front();
      v = ev.pop_front();
      if (v === 1'b1) chk(bus, x);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #100000;
    err_count++;
    conclude();
  end

  initial begin
    rst_n = 1'b0; pst_n = 1'b1; cst_n = 1'b1; adv_n = 1'b1; csl_n = 1'b0; sh = 1'b1;
    gw_n = 1'b1; bw_n = 1'b1; ln_n = 4'hf; oe_n = 1'b0; zz = 1'b0; hoe = 1'b0;
    ord = ORDER_LINEAR; fm = OUT_PIPELINED; a = ADDR_ZERO; hd = DATA_ZERO;
    err_count = 0; n_tests = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // linear burst write of all lanes from 0x11
    for (int i = 0; i < 4; i++) op(i == 0, 18'h11, 1'b0, 1'b1, 4'hf, BASE | 36'(i), 1'b0);
    // interleaved read from 0x12, processor strobe ignores write, hold and wrap
    fork
      foreach (rk[j]) op(rk[j], 18'h12, j != 0, 1'b1, 4'hf, BASE | 36'(ri[j]), 1'b1);
      @(posedge clk) ord <= ORDER_INTERLEAVED;
    join
    op(1, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0, 1'b0);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    // lane 0 write, deselected write dropped, fresh address each cycle
    op(1, 18'h11, 1'b1, 1'b0, 4'he, 36'hfffffffff, 1'b0);
    op(1, 18'h12, 1'b0, 1'b1, 4'hf, DATA_ZERO, 1'b0, 1'b0);
    op(1, 18'h11, 1'b1, 1'b1, 4'hf, BASE | 36'h1ff, 1'b1);
    op(1, 18'h12, 1'b1, 1'b1, 4'hf, BASE | 36'h1, 1'b1);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    // output enable and sleep gate the data lanes without a clock edge
    #2 oe_n = 1'b1;
    #1 chk({32'h0, doe}, {32'h0, LANES_NONE});
    oe_n = 1'b0;
    #1 chk({32'h0, doe}, {32'h0, LANES_ALL});
    zz = 1'b1;
    #1 chk({32'h0, doe}, {32'h0, LANES_NONE});
    // writes while asleep are ignored and data is kept
    op(1, 18'h12, 1'b0, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    op(1, 18'h12, 1'b0, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    fork
      op(1, 18'h12, 1'b1, 1'b1, 4'hf, BASE | 36'h1, 1'b1);
      @(posedge clk) zz <= 1'b0;
    join
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    // flow-through read answers one edge earlier
    eq.delete();
    ev.delete();
    fork
      op(1, 18'h11, 1'b1, 1'b1, 4'hf, BASE | 36'h1ff, 1'b1);
      @(posedge clk) fm <= OUT_FLOW;
    join
    op(1, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0, 1'b0);
    op(0, 18'h0, 1'b1, 1'b1, 4'hf, DATA_ZERO, 1'b0);
    conclude();
  end
endmodule
